//--- hdl/dst_trace_ctrl.sv
// Digital trace storage: converter sequencing, two tables, redisplay.
// Assumes external comparators for the SAR and cursor, an X code from
// the sweep converter, and display DACs fed from dispX and dispY.
`timescale 1ns/1ps

// ****************************************************************
// Small first-word-fall-through FIFO
// ****************************************************************
module dst_fifo #(
  parameter int W = 18,  // Word width
  parameter int D = 4    // Depth, power of two
) (
  input  wire logic         clk,       // Clock
  input  wire logic         rst,       // Synchronous reset
  input  wire logic         inValid,   // Writer has a word
  output logic              inReady,   // Room for a word
  input  wire logic [W-1:0] inData,    // Word in
  output logic              outValid,  // Word available
  input  wire logic         outReady,  // Reader takes it
  output logic [W-1:0]      outData    // Word out
);
  localparam int AW = $clog2(D);
  generate
    if (D < 2 || (1 << AW) != D) begin : g_bad
      $error("dst_fifo depth must be a power of two >= 2");
    end
  endgenerate
  logic [W-1:0] mem [D];       // Storage
  logic [AW:0]  wrQ, wrD;      // Write pointer, extra wrap bit
  logic [AW:0]  rdQ, rdD;      // Read pointer
  // Pointer update
  always_comb begin
    wrD = wrQ + (AW+1)'(inValid && inReady);
    rdD = rdQ + (AW+1)'(outValid && outReady);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wrQ <= '0;
      rdQ <= '0;
    end else begin
      wrQ <= wrD;
      rdQ <= rdD;
    end
    if (inValid && inReady) begin
      mem[wrQ[AW-1:0]] <= inData;
    end
  end
  // Full when pointers differ only in the wrap bit
  assign inReady  = !((wrQ[AW] != rdQ[AW]) && (wrQ[AW-1:0] == rdQ[AW-1:0]));
  assign outValid = (wrQ != rdQ);
  assign outData  = mem[rdQ[AW-1:0]];
endmodule

// Function
// - Two independent 512-point tables A and B
// - Digitized Y stored at digitized X address
// - Tables replayed in address order to outputs
// - Peak-hold keeps maxima at 512 positions per table
// - Frozen mode never rewrites table A
// - Difference mode shows B minus A
// - Cursor splits peak above, average below
// - View enables choose shown tables outside difference mode
// - B written every sweep, interlaced offset
// - Two to 2^17 samples, max or mean
// - 8-bit SAR, nine clocks, sync pulse
module dst_trace_ctrl (
  input  wire logic                 clk,         // 25 MHz clock
  input  wire logic                 rst,         // Synchronous reset
  input  wire logic                 hsel,        // AHB select
  input  wire logic [7:0]           haddr,       // AHB address
  input  wire logic [1:0]           htrans,      // AHB transfer type
  input  wire logic                 hwrite,      // AHB write
  input  wire logic [2:0]           hsize,       // AHB size, word only
  input  wire logic [31:0]          hwdata,      // AHB write data
  input  wire logic                 hready,      // AHB bus ready
  output logic [31:0]               hrdata,      // AHB read data
  output logic                      hreadyout,   // AHB slave ready
  output logic                      hresp,       // AHB response, OKAY
  input  wire logic                 sarAbove,    // Video above SAR DAC
  input  wire logic                 cursorAbove, // Video above cursor
  input  wire logic [dst_pkg::X_W-1:0] sweepX,   // Digitized sweep
  output logic [dst_pkg::Y_W-1:0]   sarDac,      // SAR trial code
  output logic [dst_pkg::Y_W-1:0]   cursorLevel, // Cursor DAC code
  output logic                      syncPulse,   // Conversion done
  output logic [dst_pkg::X_W-1:0]   dispX,       // Redisplay X
  output logic [dst_pkg::Y_W-1:0]   dispY,       // Redisplay Y
  output logic                      dispStrobe   // Redisplay point valid
);
  import dst_pkg::*;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  dst_ctrl_t    ctrlQ, ctrlD;       // Mode and view
  logic [7:0]   curQ, curD;         // Cursor level
  logic         wPendQ, wPendD;     // Write data phase pending
  logic [7:0]   wAddrQ, wAddrD;     // Latched write address
  logic [31:0]  rdataD;             // Next read data
  logic [X_W-1:0] lastXQ;           // Last position acquired
  typedef enum logic [2:0] {
    ACQ_IDLE = 3'b001,  // Accumulating
    ACQ_DIV  = 3'b010,  // Dividing for the mean
    ACQ_PUSH = 3'b100   // Offering the point
  } dst_acq_t;
  dst_acq_t     stQ, stD;           // Acquisition state
  logic         addrPhase;          // Valid address phase
  assign addrPhase = hsel && htrans[1] && hready;

  // Decode and write; read data prepared in the address phase
  always_comb begin
    ctrlD  = ctrlQ;
    curD   = curQ;
    wPendD = addrPhase && hwrite;
    wAddrD = haddr;
    rdataD = hrdata;
    if (wPendQ) begin
      case (wAddrQ)
        OFS_CTRL: ctrlD = {dst_mode_t'(hwdata[CTRL_MODE_LSB +: 3]),
                           hwdata[CTRL_VIEWA], hwdata[CTRL_VIEWB]};
        OFS_CURSOR: curD = hwdata[7:0];
        default: ;  // Unmapped writes ignored
      endcase
    end
    if (addrPhase && !hwrite) begin
      case (haddr)
        OFS_CTRL:   rdataD = {26'h0, ctrlQ.viewB, ctrlQ.viewA, 1'b0, ctrlQ.mode};
        OFS_CURSOR: rdataD = {24'h0, curQ};
        OFS_STATUS: rdataD = {13'h0, stQ, 6'h0, lastXQ};
        default:    rdataD = 32'h0;  // Unmapped reads as zero
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlQ     <= dst_ctrl_t'({CTRL_RST[2:0], CTRL_RST[4], CTRL_RST[5]});
      curQ      <= CURSOR_RST;
      wPendQ    <= 1'b0;
      wAddrQ    <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      ctrlQ     <= ctrlD;
      curQ      <= curD;
      wPendQ    <= wPendD;
      wAddrQ    <= wAddrD;
      hrdata    <= rdataD;
      hreadyout <= 1'b1;  // Zero wait states
      hresp     <= 1'b0;
    end
  end
  assign cursorLevel = curQ;

  // ****************************************************************
  // Successive approximation converter
  // ****************************************************************
  logic [3:0]     bitQ, bitD;       // Step 0..8
  logic [Y_W-1:0] sarD;             // Next trial code
  logic           syncD;            // Next sync
  // One bit decided per clock, ninth clock publishes and restarts
  always_comb begin
    bitD  = bitQ + 4'h1;
    sarD  = sarDac;
    syncD = 1'b0;
    if (bitQ == 4'(SAR_CYCLES - 1)) begin
      bitD  = 4'h0;
      sarD  = SAR_START;
      syncD = 1'b1;
    end else begin
      if (!sarAbove) sarD[3'(7 - bitQ)] = 1'b0;
      if (bitQ < 4'h7) sarD[3'(6 - bitQ)] = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      bitQ      <= 4'h0;
      sarDac    <= SAR_START;
      syncPulse <= 1'b0;
    end else begin
      bitQ      <= bitD;
      sarDac    <= sarD;
      syncPulse <= syncD;
    end
  end
  // Sample is the trial code as it stands in the ninth clock; the cursor is
  // compared in that same clock, so the bit belongs to this sample, not the next
  logic [Y_W-1:0] sampleQ;          // Last finished sample
  logic           sampleAbvQ;       // Cursor bit taken with that sample
  always_ff @(posedge clk) begin
    if (rst) {sampleQ, sampleAbvQ} <= '0;
    else if (syncD) {sampleQ, sampleAbvQ} <= {sarDac, cursorAbove};
  end

  // ****************************************************************
  // Per-position accumulation and division
  // ****************************************************************
  logic [NUM_W-1:0] sumQ, sumD;     // Running sum
  logic [CNT_W-1:0] cntQ, cntD;     // Samples in the sum
  logic [Y_W-1:0]   maxQ, maxD;     // Running peak
  logic             abvQ, abvD;     // Cursor comparison at the point
  logic [X_W-1:0]   lastXD;
  logic [NUM_W-1:0] remQ, remD;     // Division remainder
  logic [CNT_W-1:0] denQ, denD;     // Latched sample count
  logic [Y_W-1:0]   quoQ, quoD;     // Quotient
  logic [Y_W-1:0]   pkQ, pkD;       // Latched peak
  logic             pAbvQ, pAbvD;   // Latched cursor bit
  logic [X_W-1:0]   pxQ, pxD;       // Latched position
  logic [2:0]       dbQ, dbD;       // Quotient bit index
  logic [NUM_W-1:0] trial;          // Shifted denominator
  logic             pushReady;      // FIFO room
  dst_point_t       pushWord;       // Finished point
  logic             newX;           // Sweep moved on
  assign newX  = syncPulse && (sweepX != lastXQ);
  assign trial = NUM_W'(denQ) << dbQ;
  // Points are dropped while the engine is still busy with the last one
  always_comb begin
    {sumD, cntD, maxD, abvD, lastXD} = {sumQ, cntQ, maxQ, abvQ, lastXQ};
    {remD, denD, quoD, pkD, pAbvD, pxD, dbD} =
      {remQ, denQ, quoQ, pkQ, pAbvQ, pxQ, dbQ};
    stD = stQ;
    if (syncPulse) begin
      if (newX) begin
        if (stQ == ACQ_IDLE && cntQ >= CNT_W'(MIN_SAMPLES)) begin
          {remD, denD, pkD, pAbvD, pxD} = {sumQ, cntQ, maxQ, abvQ, lastXQ};
          quoD = 8'h00;
          dbD  = 3'h7;
          stD  = ACQ_DIV;
        end
        sumD = NUM_W'(sampleQ);
        cntD = CNT_W'(1);
        maxD = sampleQ;
        lastXD = sweepX;
      end else if (cntQ < CNT_MAX) begin
        sumD = sumQ + NUM_W'(sampleQ);
        cntD = cntQ + CNT_W'(1);
        if (sampleQ > maxQ) maxD = sampleQ;
      end
      abvD = sampleAbvQ;
    end
    case (stQ)
      ACQ_DIV: begin  // Restoring division, MSB first
        if (remQ >= trial) begin
          remD = remQ - trial;
          quoD[dbQ] = 1'b1;
        end
        dbD = dbQ - 3'h1;
        if (dbQ == 3'h0) stD = ACQ_PUSH;
      end
      ACQ_PUSH: if (pushReady) stD = ACQ_IDLE;
      ACQ_IDLE: ;
      default: stD = ACQ_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      {sumQ, cntQ, maxQ, abvQ, lastXQ} <= '0;
      {remQ, denQ, quoQ, pkQ, pAbvQ, pxQ, dbQ} <= '0;
      stQ <= ACQ_IDLE;
    end else begin
      {sumQ, cntQ, maxQ, abvQ, lastXQ} <= {sumD, cntD, maxD, abvD, lastXD};
      {remQ, denQ, quoQ, pkQ, pAbvQ, pxQ, dbQ} <=
        {remD, denD, quoD, pkD, pAbvD, pxD, dbD};
      stQ <= stD;
    end
  end
  // Split mode lets the cursor pick peak or mean; other modes store peak
  assign pushWord.x = pxQ;
  assign pushWord.y = (ctrlQ.mode == MODE_AVG && !pAbvQ) ? quoQ : pkQ;

  // ****************************************************************
  // FIFO and table writer
  // ****************************************************************
  dst_point_t popWord;              // Point to store
  logic       popValid;             // Point waiting
  logic       popReady;             // Writer slot free
  logic       phaseQ;               // Display owns odd cycles
  dst_fifo #(.W($bits(dst_point_t)), .D(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (stQ == ACQ_PUSH),
    .inReady  (pushReady),
    .inData   (pushWord),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popWord)
  );
  logic [Y_W-1:0] tblA [TBL_DEPTH];
  logic [Y_W-1:0] tblB [TBL_DEPTH];
  logic [8:0]     wIdx;              // Table index
  logic           wrA, wrB;          // Write strobes
  logic [Y_W-1:0] newA, newB;        // Values to write
  // Writer takes the even slots whatever the display does, so a point waits one clock at most
  assign popReady = !phaseQ;
  assign wIdx     = popWord.x[X_W-1:1];
  always_comb begin
    wrB  = popValid && popReady;
    wrA  = wrB && ctrlQ.mode != MODE_SAVE && ctrlQ.mode != MODE_DIFF;
    newA = popWord.y;
    newB = popWord.y;
    if (ctrlQ.mode == MODE_PEAK) begin
      if (tblA[wIdx] > newA) newA = tblA[wIdx];
      if (tblB[wIdx] > newB) newB = tblB[wIdx];
    end
  end
  always_ff @(posedge clk) begin
    if (wrA) tblA[wIdx] <= newA;
    if (wrB) tblB[wIdx] <= newB;
  end

  // ****************************************************************
  // Redisplay scan
  // ****************************************************************
  logic [X_W-1:0] scanQ, scanD;     // Even = A, odd = B (interlaced)
  logic [Y_W-1:0] outYD;
  logic           outVD;
  logic [Y_W-1:0] rdA, rdB;
  assign rdA = tblA[scanQ[X_W-1:1]];
  assign rdB = tblB[scanQ[X_W-1:1]];
  // Scan in address order, one point every two clocks
  always_comb begin
    scanD = phaseQ ? scanQ + X_W'(1) : scanQ;
    outVD = 1'b0;
    outYD = dispY;
    if (phaseQ) begin
      if (ctrlQ.mode == MODE_DIFF) begin
        outVD = scanQ[0];
        outYD = rdB > rdA ? rdB - rdA : 8'h00;
      end else begin
        outVD = scanQ[0] ? ctrlQ.viewB : ctrlQ.viewA;
        outYD = scanQ[0] ? rdB : rdA;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      phaseQ <= 1'b0;
      scanQ  <= '0;
      dispX  <= '0;
      dispY  <= '0;
      dispStrobe <= 1'b0;
    end else begin
      phaseQ <= !phaseQ;
      scanQ  <= scanD;
      dispX  <= phaseQ ? scanQ : dispX;
      dispY  <= outYD;
      dispStrobe <= outVD;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sync_period: assert property (@(posedge clk) disable iff (rst)
    syncPulse |=> !syncPulse [*8] ##1 syncPulse)
    else $error("sync spacing not nine clocks");
  a_sar_restart: assert property (@(posedge clk) disable iff (rst)
    syncPulse |-> sarDac == SAR_START)
    else $error("SAR not restarted on sync");
  a_div_length: assert property (@(posedge clk) disable iff (rst)
    $rose(stQ == ACQ_DIV) |-> (stQ == ACQ_DIV) [*8] ##1 (stQ == ACQ_PUSH))
    else $error("division not eight clocks");
  a_a_frozen: assert property (@(posedge clk) disable iff (rst)
    (ctrlQ.mode == MODE_SAVE || ctrlQ.mode == MODE_DIFF) |-> !wrA)
    else $error("table A written while frozen");
  a_b_always: assert property (@(posedge clk) disable iff (rst)
    popValid |-> ##[0:1] wrB)
    else $error("table B skipped a point");
  a_peak_keeps: assert property (@(posedge clk) disable iff (rst)
    (wrB && ctrlQ.mode == MODE_PEAK) |-> newB >= tblB[wIdx])
    else $error("peak hold lowered a value");
  a_split_peak: assert property (@(posedge clk) disable iff (rst)
    (stQ == ACQ_PUSH && ctrlQ.mode == MODE_AVG && pAbvQ) |-> pushWord.y == pkQ)
    else $error("above cursor not peak");
  a_view_gate: assert property (@(posedge clk) disable iff (rst)
    (dispStrobe && $past(ctrlQ.mode) != MODE_DIFF) |->
      ($past(scanQ[0]) ? $past(ctrlQ.viewB) : $past(ctrlQ.viewA)))
    else $error("disabled table shown");
  a_diff_only_b: assert property (@(posedge clk) disable iff (rst)
    (dispStrobe && $past(ctrlQ.mode) == MODE_DIFF) |-> dispX[0])
    else $error("difference shown off B slot");
endmodule

//--- hdl/dst_pkg.sv
// Package for the digital trace storage block: constants, modes, carriers.
// Assumes a single 25 MHz clock domain and an AHB-Lite register bus.
package dst_pkg;
  // ****************************************************************
  // Table geometry and converter widths
  // ****************************************************************
  localparam int TBL_DEPTH   = 512;  // Points per table
  localparam int X_W         = 10;   // Combined display position width
  localparam int Y_W         = 8;    // Amplitude width
  localparam int CNT_W       = 18;   // Sample counter, holds up to 2^17
  localparam int NUM_W       = Y_W + CNT_W;  // Running sum width
  localparam int SAR_CYCLES  = 9;    // Clocks per conversion
  localparam int MIN_SAMPLES = 2;    // Least samples per position
  localparam int FIFO_DEPTH  = 4;    // Words between acquisition and tables
  localparam logic [CNT_W-1:0] CNT_MAX = 18'h20000;  // 2^17 samples
  localparam logic [Y_W-1:0]   SAR_START = 8'h80;    // Conversion start code
  // ****************************************************************
  // Register map (byte addresses) and fields
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Mode and view enables
  localparam logic [7:0] OFS_CURSOR = 8'h04;  // Threshold cursor level
  localparam logic [7:0] OFS_STATUS = 8'h08;  // Position and engine state
  localparam int CTRL_MODE_LSB = 0;  // Mode field, 3 bits
  localparam int CTRL_VIEWA    = 4;  // Show table A
  localparam int CTRL_VIEWB    = 5;  // Show table B
  localparam logic [7:0] CTRL_RST   = 8'h30;  // View mode, both tables shown
  localparam logic [7:0] CURSOR_RST = 8'h80;  // Cursor mid screen
  // ****************************************************************
  // Storage modes
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_VIEW = 3'h0,  // Plain acquire and show
    MODE_PEAK = 3'h1,  // Hold maxima over sweeps
    MODE_SAVE = 3'h2,  // Table A frozen
    MODE_DIFF = 3'h3,  // A frozen, show B minus A
    MODE_AVG  = 3'h4   // Split peak and average
  } dst_mode_t;
  // One finished point on its way to the tables
  typedef struct packed {
    logic [X_W-1:0] x;  // Sweep position
    logic [Y_W-1:0] y;  // Amplitude
  } dst_point_t;
  // Software controls
  typedef struct packed {
    dst_mode_t mode;   // Storage mode
    logic      viewA;  // Table A shown
    logic      viewB;  // Table B shown
  } dst_ctrl_t;
endpackage

//--- verification/dst_front_model.sv
// Model of the video detector comparators facing the block's converters.
// Assumes the bench sets the detected video level as an 8-bit code.
`timescale 1ns/1ps
module dst_front_model (
  input  wire logic [dst_pkg::Y_W-1:0] videoLevel,  // Detected video as a code
  input  wire logic [dst_pkg::Y_W-1:0] sarDac,      // Trial code from the block
  input  wire logic [dst_pkg::Y_W-1:0] cursorLevel, // Cursor code from the block
  output logic                         sarAbove,    // Video at or above trial
  output logic                         cursorAbove  // Video above cursor
);
  import dst_pkg::*;
  // ****************************************************************
  // Ideal comparators
  // ****************************************************************
  // At-or-above, so a settled conversion lands exactly on the video code
  always_comb begin
    sarAbove    = (videoLevel >= sarDac);
    cursorAbove = (videoLevel > cursorLevel);
  end
endmodule

//--- verification/digital_storage_trace_control_test.sv
// Self-checking bench for the trace storage block: registers, sweeps, redisplay.
// Assumes the front-end model closes the converter loop; hready is hreadyout.
`timescale 1ns/1ps
module digital_storage_trace_control_test;
  import dst_pkg::*;
  logic           clk, rst, hsel, hwrite, hreadyout, hresp;  // Clock, reset, bus bits
  logic [7:0]     haddr;                                      // Bus address
  logic [1:0]     htrans;                                     // Transfer type
  logic [2:0]     hsize;                                      // Transfer size
  logic [31:0]    hwdata, hrdata;                             // Bus data
  logic           sarAbove, cursorAbove, syncPulse, dispStrobe; // Converter, display
  logic [X_W-1:0] sweepX, dispX;                              // Positions
  logic [Y_W-1:0] sarDac, cursorLevel, dispY, videoLevel;     // Codes
  logic [Y_W-1:0] expA [8];                                   // Expected table A
  logic [Y_W-1:0] expB [8];                                   // Expected table B slots
  int             miscompares, n_compared;                    // Tallies
  dst_trace_ctrl dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sarAbove(sarAbove), .cursorAbove(cursorAbove),
    .sweepX(sweepX), .sarDac(sarDac), .cursorLevel(cursorLevel), .syncPulse(syncPulse),
    .dispX(dispX), .dispY(dispY), .dispStrobe(dispStrobe));
  dst_front_model front (.videoLevel(videoLevel), .sarDac(sarDac),
    .cursorLevel(cursorLevel), .sarAbove(sarAbove), .cursorAbove(cursorAbove));
  // ****************************************************************
  // Clock, compare and close
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************************************
  // Bus master
  // ****************************************************************
  // Samples hready at each rising edge; returns at the edge that ends the phase
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        miscompares++;
        complete_run();
      end
    end while (hreadyout !== 1'b1);
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, unmapped read, cursor output, every mode held
  task regs;
    logic [31:0] r;
    ahb(1'b0, OFS_CTRL, 32'h0, r);
    check(r, {24'h0, CTRL_RST});
    ahb(1'b0, OFS_CURSOR, 32'h0, r);
    check(r, {24'h0, CURSOR_RST});
    ahb(1'b0, 8'h0C, 32'h0, r);
    check(r, 32'h0);
    ahb(1'b1, OFS_CURSOR, 32'h5A, r);
    ahb(1'b0, OFS_CURSOR, 32'h0, r);
    check(r, 32'h5A);
    check(32'(cursorLevel), 32'h5A);
    for (int m = 0; m < 5; m++) begin
      ahb(1'b1, OFS_CTRL, 32'(m) | 32'h30, r);
      ahb(1'b0, OFS_CTRL, 32'h0, r);
      check(r, 32'(m) | 32'h30);
    end
    check(32'(hresp), 32'h0);
  endtask
  // Distance between conversion-done pulses
  task sync_period;
    int n;
    n = 0;
    while (syncPulse !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (syncPulse !== 1'b1 && n < 30);
    check(32'(n), 32'd9);
  endtask
  // Zero video around each step, so a conversion that straddles a step stays low
  task sweep(input logic [Y_W-1:0] base);
    for (int i = 0; i <= 8; i++) begin
      videoLevel <= 8'h00;
      repeat (18) @(posedge clk);
      sweepX <= 10'(2 * i);
      repeat (18) @(posedge clk);
      videoLevel <= base + 8'(8 * i);
      repeat (36) @(posedge clk);
    end
  endtask
  // One full scan after settling: order, shown slots, amplitudes
  task scan(input logic aOn, input logic bOn);
    logic [X_W-1:0] prevX;
    int             seen;
    seen = 0;
    repeat (2100) @(posedge clk);
    repeat (2100) begin
      @(negedge clk);
      if (dispStrobe === 1'b1) begin
        if (seen > 0) check(32'(dispX), 32'(10'(prevX + ((aOn & bOn) ? 10'h1 : 10'h2))));
        check(32'(dispX[0] ? bOn : aOn), 32'h1);
        if (dispX < 10'h10) check(32'(dispY), 32'(dispX[0] ? expB[dispX[3:1]] : expA[dispX[3:1]]));
        prevX = dispX;
        seen++;
      end
    end
    check(32'(seen > 0), 32'h1);
  endtask
  // Split average in lockstep with the converter, two samples per position:
  // even positions end below the cursor (mean), odd ones above it (peak)
  task avg_sweep;
    int          n;
    logic [31:0] r;
    n = 0;
    @(posedge clk);
    while (syncPulse !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check(32'(n < 20), 32'h1);
    for (int i = 0; i <= 8; i++) begin
      repeat (8) @(posedge clk);
      videoLevel <= i[0] ? 8'(8 * i) : 8'h20 + 8'(8 * i);
      @(posedge clk);
      sweepX <= 10'(2 * i);
      repeat (8) @(posedge clk);
      videoLevel <= i[0] ? 8'h60 + 8'(8 * i) : 8'(8 * i);
      @(posedge clk);
    end
    repeat (30) @(posedge clk);
    ahb(1'b0, OFS_STATUS, 32'h0, r);
    check(r, 32'h0001_0010);
  endtask
  task set_ctrl(input logic [31:0] v);
    logic [31:0] r;
    ahb(1'b1, OFS_CTRL, v, r);
  endtask
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sweepX = 10'h000;
    videoLevel = 8'h00;
    miscompares = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    regs();
    sync_period();
    // Plain view: both tables take the sweep
    set_ctrl(32'h30);
    sweep(8'h40);
    for (int i = 0; i < 8; i++) expA[i] = 8'h40 + 8'(8 * i);
    for (int i = 0; i < 8; i++) expB[i] = expA[i];
    scan(1'b1, 1'b1);
    // Peak hold: a lower sweep leaves the maxima
    set_ctrl(32'h31);
    sweep(8'h20);
    scan(1'b1, 1'b1);
    // Frozen A: only B follows a higher sweep
    set_ctrl(32'h32);
    sweep(8'h60);
    for (int i = 0; i < 8; i++) expB[i] = 8'h60 + 8'(8 * i);
    scan(1'b1, 1'b1);
    // Difference: odd slots carry B minus the frozen A
    set_ctrl(32'h33);
    sweep(8'h70);
    for (int i = 0; i < 8; i++) expB[i] = 8'h30;
    scan(1'b0, 1'b1);
    // View A alone, no new sweep
    set_ctrl(32'h10);
    scan(1'b1, 1'b0);
    // Split average: mean below the cursor, peak above it
    set_ctrl(32'h34);
    avg_sweep();
    for (int i = 0; i < 8; i++) expA[i] = i[0] ? 8'h60 + 8'(8 * i) : 8'h10 + 8'(8 * i);
    for (int i = 0; i < 8; i++) expB[i] = expA[i];
    scan(1'b1, 1'b1);
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    complete_run();
  end
endmodule
